/* rtl/ntsc_pkg.sv */
// Constants, types and register map shared by the network time block.
`default_nettype none
package ntsc_pkg;

  localparam int CLK_FREQ_MHZ      = 40;
  localparam int PRESCALE_MIN_LOG2 = 5;
  localparam int PRESCALE_CNT_W    = 13;

  localparam logic [7:0] ADDR_MODE       = 8'h00;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h01;
  localparam logic [7:0] ADDR_MASTER_ID  = 8'h02;
  localparam logic [7:0] ADDR_TIME_LO    = 8'h10;
  localparam logic [7:0] ADDR_TIME_HI    = 8'h11;
  localparam logic [7:0] ADDR_DIFF_LO    = 8'h32;
  localparam logic [7:0] ADDR_DIFF_HI    = 8'h33;
  localparam logic [7:0] ADDR_CARRY_LO   = 8'h34;
  localparam logic [7:0] ADDR_CARRY_HI   = 8'h35;

  localparam int MODE_STAMP_SEND_BIT = 0;
  localparam int MODE_TIME_HALT_BIT  = 1;
  localparam int MODE_SW_RESET_BIT   = 7;
  localparam int INT_UNLOCK_BIT      = 0;

  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [4:0]  MASTER_ID_RESET = 5'h00;
  localparam logic [15:0] CARRY_RESET     = 16'h0000;
  localparam logic [15:0] TIME_RESET      = 16'h0000;

  localparam logic signed [15:0] LOCK_WINDOW   = 16'sh0002;
  localparam logic signed [15:0] SLOW_LIMIT    = 16'sh0002;
  localparam logic signed [15:0] FAST_LIMIT    = -16'sh0001;
  localparam logic [1:0]         LOCK_RUN_NEED = 2'h3;

  typedef struct packed {
    logic       offsetSourceSelect;
    logic [1:0] rsvdHigh;
    logic [4:0] manualOffsetValue;
    logic [3:0] rsvdLow;
    logic [3:0] pulseDigitSelect;
  } carry_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  sourceId;
    logic [15:0] stampTime;
  } rx_stamp_t;

  typedef enum logic [1:0] {
    SYNC_PRESET = 2'b01,
    SYNC_TRACK  = 2'b10
  } sync_state_t;

  // Receive-path latency in microseconds per data rate code at this clock.
  function automatic logic [8:0] autoOffsetUs(input logic [2:0] rate);
    case (rate)
      3'h0:    autoOffsetUs = 9'h00B;
      3'h1:    autoOffsetUs = 9'h016;
      3'h2:    autoOffsetUs = 9'h02C;
      3'h3:    autoOffsetUs = 9'h058;
      3'h4:    autoOffsetUs = 9'h0B0;
      default: autoOffsetUs = 9'h160;
    endcase
  endfunction

endpackage
`default_nettype wire

/* rtl/network_time_prescaler.sv */
// Prescaler that makes the time counter's resolution tick, with a trimmable period.
`timescale 1ns/1ps
`default_nettype none
module network_time_prescaler (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       halt,
  input  wire logic       restart,
  input  wire logic [2:0] prescaleSelect,
  input  wire logic       slowDown,
  input  wire logic       speedUp,
  output logic            tick
);
  import ntsc_pkg::*;

  logic [PRESCALE_CNT_W-1:0] count_q;
  logic [PRESCALE_CNT_W-1:0] periodLen;

  // One clock of trim per tick keeps the counter monotonic while it tracks.
  always_comb
  begin
    periodLen = PRESCALE_CNT_W'(13'h0001 << (PRESCALE_MIN_LOG2 + 32'(prescaleSelect)));
    if (slowDown)
    begin
      periodLen = periodLen + 13'h0001;
    end
    else if (speedUp)
    begin
      periodLen = periodLen - 13'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
      tick    <= 1'b0;
    end
    else if (restart || halt)
    begin
      count_q <= '0;
      tick    <= 1'b0;
    end
    else if (count_q >= periodLen - 13'h0001)
    begin
      count_q <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      count_q <= count_q + 13'h0001;
      tick    <= 1'b0;
    end
  end

endmodule // network_time_prescaler
`default_nettype wire

/* rtl/word_read_latch.sv */
// Holds the odd byte of a 16-bit value when its even byte is read.
`timescale 1ns/1ps
`default_nettype none
module word_read_latch (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] word,
  input  wire logic        readEven,
  output logic      [7:0]  heldHigh
);

  // Without this the two byte reads could straddle a carry and tear.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      heldHigh <= 8'h00;
    end
    else if (readEven)
    begin
      heldHigh <= word[15:8];
    end
  end

endmodule // word_read_latch
`default_nettype wire

/* rtl/network_time_sync_counter.sv */
// Network time counter with master stamping, slave preset and phase tracking.
`timescale 1ns/1ps
`default_nettype none
module network_time_sync_counter (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        hostAddr,
  input  wire logic              hostRd,
  input  wire logic              hostWr,
  input  wire logic [7:0]        hostWrData,
  output logic      [7:0]        hostRdData,
  input  wire logic [4:0]        nodeIdPin,
  input  wire logic [2:0]        prescaleSelectPin,
  input  wire logic [2:0]        dataRateSelect,
  input  wire ntsc_pkg::rx_stamp_t rxStamp,
  output logic                   txStampEnable,
  output logic      [15:0]       txStampValue,
  output logic                   digitPulseOut_n,
  output logic                   syncUnlockedFlag,
  output logic                   clockMaster
);
  import ntsc_pkg::*;

  logic [7:0]        mode_q;
  logic [4:0]        masterNodeId_q;
  carry_cfg_t        carryCfg_q;
  logic              swReset_q;
  logic [4:0]        nodeIdMeta_q;
  logic [4:0]        nodeId_q;
  logic [2:0]        prescaleMeta_q;
  logic [2:0]        prescaleSelect_q;
  logic [1:0]        syncFill_q;
  logic [15:0]       networkTime_q;
  logic [15:0]       phaseDiff_q;
  logic              haltPrev_q;
  logic              rearm_q;
  sync_state_t       syncState_q;
  logic              slowDown_q;
  logic              speedUp_q;
  logic [1:0]        lockRun_q;
  logic              tick;
  logic              timeHalt;
  logic              fromMaster;
  logic              useManual;
  logic [15:0]       offsetTicks;
  logic [15:0]       expectedTime;
  logic signed [15:0] countDiff;
  logic              withinWindow;
  logic [15:0]       absDiff;
  logic [15:0]       nextTime;
  logic [7:0]        timeHeldHigh;
  logic [7:0]        diffHeldHigh;
  logic              writeMasterId;

  assign timeHalt      = mode_q[MODE_TIME_HALT_BIT];
  assign writeMasterId = hostWr && (hostAddr == ADDR_MASTER_ID);

  // The node ID and prescale pins pass two flops before anything looks at them.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nodeIdMeta_q     <= 5'h00;
      nodeId_q         <= 5'h00;
      prescaleMeta_q   <= 3'h0;
      prescaleSelect_q <= 3'h0;
      syncFill_q       <= 2'b00;
    end
    else
    begin
      nodeIdMeta_q     <= nodeIdPin;
      nodeId_q         <= nodeIdMeta_q;
      prescaleMeta_q   <= prescaleSelectPin;
      prescaleSelect_q <= prescaleMeta_q;
      // The fill flag keeps the reset value of the pins from posing as a master ID match.
      syncFill_q       <= {syncFill_q[0], 1'b1};
    end
  end

  // Host writes; the software reset bit is a one-cycle self-clearing strobe.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q         <= MODE_RESET;
      masterNodeId_q <= MASTER_ID_RESET;
      carryCfg_q     <= CARRY_RESET;
      swReset_q      <= 1'b0;
    end
    else
    begin
      swReset_q <= hostWr && (hostAddr == ADDR_MODE) && hostWrData[MODE_SW_RESET_BIT];
      if (hostWr)
      begin
        case (hostAddr)
          ADDR_MODE:      mode_q <= hostWrData & 8'h03;
          ADDR_MASTER_ID: masterNodeId_q <= hostWrData[4:0];
          ADDR_CARRY_LO:  carryCfg_q[7:0] <= hostWrData & 8'h0F;
          ADDR_CARRY_HI:  carryCfg_q[15:8] <= hostWrData & 8'h9F;
          default:        ;
        endcase
      end
    end
  end

  // Master role is recognised one cycle after the ID comparison settles.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clockMaster   <= 1'b0;
      txStampEnable <= 1'b0;
      txStampValue  <= TIME_RESET;
    end
    else
    begin
      clockMaster   <= syncFill_q[1] && (masterNodeId_q == nodeId_q);
      txStampEnable <= mode_q[MODE_STAMP_SEND_BIT] || clockMaster;
      txStampValue  <= networkTime_q;
    end
  end

  assign fromMaster = rxStamp.valid && !clockMaster && (rxStamp.sourceId == masterNodeId_q);

  // Manual offset only counts at the slow prescale settings.
  assign useManual = carryCfg_q.offsetSourceSelect && prescaleSelect_q[2];

  always_comb
  begin
    if (useManual)
    begin
      offsetTicks = {11'h000, carryCfg_q.manualOffsetValue};
    end
    else
    begin
      offsetTicks = 16'((32'(autoOffsetUs(dataRateSelect)) * CLK_FREQ_MHZ)
                        >> (PRESCALE_MIN_LOG2 + 32'(prescaleSelect_q)));
    end
  end

  assign expectedTime = rxStamp.stampTime + offsetTicks;
  assign countDiff    = signed'(networkTime_q - expectedTime);
  assign withinWindow = (countDiff >= -LOCK_WINDOW) && (countDiff <= LOCK_WINDOW);
  assign absDiff      = countDiff[15] ? 16'(-countDiff) : 16'(countDiff);
  assign nextTime     = networkTime_q + 16'h0001;

  network_time_prescaler prescaler (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .halt           (timeHalt),
    .restart        (swReset_q),
    .prescaleSelect (prescaleSelect_q),
    .slowDown       (slowDown_q),
    .speedUp        (speedUp_q),
    .tick           (tick)
  );

  // Preset is re-armed on a halt release, a master ID write or a reset.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      haltPrev_q <= 1'b0;
      rearm_q    <= 1'b0;
    end
    else
    begin
      haltPrev_q <= timeHalt;
      rearm_q    <= (haltPrev_q && !timeHalt) || writeMasterId || swReset_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncState_q <= SYNC_PRESET;
    end
    else if (rearm_q || writeMasterId)
    begin
      syncState_q <= SYNC_PRESET;
    end
    else
    begin
      case (syncState_q)
        SYNC_PRESET:
        begin
          if (fromMaster)
          begin
            syncState_q <= SYNC_TRACK;
          end
        end
        SYNC_TRACK:
        begin
          syncState_q <= SYNC_TRACK;
        end
        default:
        begin
          syncState_q <= SYNC_PRESET;
        end
      endcase
    end
  end

  // The counter runs from reset; only the first master packet after each re-arm may load it.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      networkTime_q <= TIME_RESET;
    end
    else if (swReset_q)
    begin
      networkTime_q <= TIME_RESET;
    end
    else if (fromMaster && (syncState_q == SYNC_PRESET) && !rearm_q)
    begin
      networkTime_q <= expectedTime;
    end
    else if (tick && !timeHalt)
    begin
      networkTime_q <= nextTime;
    end
  end

  // Speed trim holds from one comparison to the next.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slowDown_q <= 1'b0;
      speedUp_q  <= 1'b0;
    end
    else if (clockMaster || (syncState_q != SYNC_TRACK) || rearm_q)
    begin
      slowDown_q <= 1'b0;
      speedUp_q  <= 1'b0;
    end
    else if (fromMaster)
    begin
      slowDown_q <= (countDiff >= SLOW_LIMIT);
      speedUp_q  <= (countDiff <= FAST_LIMIT);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseDiff_q <= 16'h0000;
    end
    else if (fromMaster && (syncState_q == SYNC_TRACK))
    begin
      phaseDiff_q <= {countDiff[15], absDiff[14:0]};
    end
  end

  // The set side wins: any out-of-window reception unlocks at once.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncUnlockedFlag <= 1'b1;
      lockRun_q        <= 2'h0;
    end
    else if (swReset_q || rearm_q)
    begin
      syncUnlockedFlag <= 1'b1;
      lockRun_q        <= 2'h0;
    end
    else if (clockMaster)
    begin
      syncUnlockedFlag <= 1'b0;
      lockRun_q        <= 2'h0;
    end
    else if (fromMaster && (syncState_q == SYNC_TRACK))
    begin
      if (!withinWindow)
      begin
        syncUnlockedFlag <= 1'b1;
        lockRun_q        <= 2'h0;
      end
      else if (lockRun_q >= LOCK_RUN_NEED - 2'h1)
      begin
        syncUnlockedFlag <= 1'b0;
        lockRun_q        <= LOCK_RUN_NEED;
      end
      else
      begin
        lockRun_q <= lockRun_q + 2'h1;
      end
    end
  end

  // Pulse low for exactly one tick so synced nodes line up their edges.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      digitPulseOut_n <= 1'b1;
    end
    else if (swReset_q || timeHalt)
    begin
      digitPulseOut_n <= 1'b1;
    end
    else if (tick)
    begin
      digitPulseOut_n <= !(networkTime_q[carryCfg_q.pulseDigitSelect] ^ nextTime[carryCfg_q.pulseDigitSelect]);
    end
  end

  word_read_latch timeLatch (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .word     (networkTime_q),
    .readEven (hostRd && (hostAddr == ADDR_TIME_LO)),
    .heldHigh (timeHeldHigh)
  );

  word_read_latch diffLatch (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .word     (phaseDiff_q),
    .readEven (hostRd && (hostAddr == ADDR_DIFF_LO)),
    .heldHigh (diffHeldHigh)
  );

  // Unmapped addresses read as zero.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hostRdData <= 8'h00;
    end
    else if (hostRd)
    begin
      case (hostAddr)
        ADDR_MODE:       hostRdData <= mode_q;
        ADDR_INT_STATUS: hostRdData <= 8'(syncUnlockedFlag) << INT_UNLOCK_BIT;
        ADDR_MASTER_ID:  hostRdData <= {3'h0, masterNodeId_q};
        ADDR_TIME_LO:    hostRdData <= networkTime_q[7:0];
        ADDR_TIME_HI:    hostRdData <= timeHeldHigh;
        ADDR_DIFF_LO:    hostRdData <= phaseDiff_q[7:0];
        ADDR_DIFF_HI:    hostRdData <= diffHeldHigh;
        ADDR_CARRY_LO:   hostRdData <= carryCfg_q[7:0];
        ADDR_CARRY_HI:   hostRdData <= carryCfg_q[15:8];
        default:         hostRdData <= 8'h00;
      endcase
    end
  end

  master_stamps_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clockMaster |=> txStampEnable)
    else $error("Master node did not enable time stamping.");

  preset_load_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (fromMaster && syncState_q == SYNC_PRESET && !rearm_q && !swReset_q && !writeMasterId)
    |=> (networkTime_q == $past(expectedTime)) && (syncState_q == SYNC_TRACK))
    else $error("First master packet did not preset the counter.");

  slow_down_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (fromMaster && syncState_q == SYNC_TRACK && !rearm_q && countDiff >= SLOW_LIMIT) |=> slowDown_q && !speedUp_q)
    else $error("Counter ahead by two or more was not slowed.");

  speed_up_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (fromMaster && syncState_q == SYNC_TRACK && !rearm_q && countDiff <= FAST_LIMIT) |=> speedUp_q && !slowDown_q)
    else $error("Counter behind was not sped up.");

  unlock_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (fromMaster && syncState_q == SYNC_TRACK && !withinWindow) |=> syncUnlockedFlag)
    else $error("Out-of-window difference did not set unlock.");

  lock_after_three_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($fell(syncUnlockedFlag) && !$past(clockMaster)) |-> lockRun_q == LOCK_RUN_NEED)
    else $error("Lock reached before three in-window receptions.");

  pulse_width_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!digitPulseOut_n && !tick && !timeHalt && !swReset_q) |=> !digitPulseOut_n)
    else $error("Carry pulse ended before the next tick.");

  rearm_on_write_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    writeMasterId |=> syncState_q == SYNC_PRESET ##1 syncState_q == SYNC_PRESET)
    else $error("Master ID write did not re-arm the preset.");

  auto_offset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !prescaleSelect_q[2] |-> !useManual)
    else $error("Manual offset used with low prescale top bit.");

  preset_seen_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    syncState_q == SYNC_PRESET ##1 syncState_q == SYNC_TRACK);

  lock_seen_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(syncUnlockedFlag) && !clockMaster);

  pulse_seen_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(digitPulseOut_n));

endmodule // network_time_sync_counter
`default_nettype wire

/* tb/peer_node_model.sv */
// Peer node that sends time-stamped packets towards the block.
`timescale 1ns/1ps
`default_nettype none
module peer_node_model (
  input  wire logic              sys_clk,
  output var ntsc_pkg::rx_stamp_t rxStamp
);
  import ntsc_pkg::*;

  initial rxStamp = '0;

  // The bench sends far more often than the drift limit asks.
  task automatic send(input logic [4:0] id, input logic [15:0] t);
    @(negedge sys_clk);
    rxStamp <= '{valid: 1'b1, sourceId: id, stampTime: t};
    @(negedge sys_clk);
    // Fields are not held after the packet, so show them inverted.
    rxStamp <= '{valid: 1'b0, sourceId: ~id, stampTime: ~t};
  endtask
endmodule // peer_node_model
`default_nettype wire

/* tb/network_time_sync_counter_tb.sv */
// Self-checking bench for the network time block.
`timescale 1ns/1ps
`default_nettype none
module network_time_sync_counter_tb;
  import ntsc_pkg::*;

  // Eleven microseconds of receive latency at 40 MHz over 32 clocks a tick.
  localparam logic [15:0] AUTO_OFS = 16'h000D;

  logic        sys_clk           = 1'b0;
  logic        reset_n           = 1'b0;
  logic [7:0]  hostAddr          = 8'h00;
  logic        hostRd            = 1'b0;
  logic        hostWr            = 1'b0;
  logic [7:0]  hostWrData        = 8'h00;
  logic [4:0]  nodeIdPin         = 5'h03;
  logic [2:0]  prescaleSelectPin = 3'h0;
  logic [2:0]  dataRateSelect    = 3'h0;
  logic [7:0]  hostRdData;
  rx_stamp_t   rxStamp;
  logic        txStampEnable;
  logic [15:0] txStampValue;
  logic        digitPulseOut_n;
  logic        syncUnlockedFlag;
  logic        clockMaster;
  logic [15:0] t0;
  logic [15:0] t1;
  logic [15:0] v;
  int          low;
  int          run;
  int          maxRun;
  int          miscompares = 0;
  int          comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  network_time_sync_counter network_time_sync_counter_i (
    .sys_clk          (sys_clk),
    .reset_n          (reset_n),
    .hostAddr         (hostAddr),
    .hostRd           (hostRd),
    .hostWr           (hostWr),
    .hostWrData       (hostWrData),
    .hostRdData       (hostRdData),
    .nodeIdPin        (nodeIdPin),
    .prescaleSelectPin(prescaleSelectPin),
    .dataRateSelect   (dataRateSelect),
    .rxStamp          (rxStamp),
    .txStampEnable    (txStampEnable),
    .txStampValue     (txStampValue),
    .digitPulseOut_n  (digitPulseOut_n),
    .syncUnlockedFlag (syncUnlockedFlag),
    .clockMaster      (clockMaster)
  );

  peer_node_model peer_node_model_i (
    .sys_clk(sys_clk),
    .rxStamp(rxStamp)
  );

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A tick may land between sampling and the packet, so allow one more.
  task automatic near(input string what, input logic [15:0] seen, input logic [15:0] exp);
    chk(what, {15'h0000, (seen - exp) <= 16'h0001}, 16'h0001);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    hostAddr   = a;
    hostWrData = d;
    hostWr     = 1'b1;
    @(negedge sys_clk);
    hostWr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    hostAddr = a;
    hostRd   = 1'b1;
    @(negedge sys_clk);
    hostRd = 1'b0;
    d      = {8'h00, hostRdData};
  endtask

  // Even byte first, so the odd byte belongs to the same sample.
  task automatic rd16(input logic [7:0] a, output logic [15:0] w);
    @(negedge sys_clk);
    hostAddr = a;
    hostRd   = 1'b1;
    @(negedge sys_clk);
    hostAddr = a + 8'h01;
    w[7:0]   = hostRdData;
    @(negedge sys_clk);
    hostRd  = 1'b0;
    w[15:8] = hostRdData;
  endtask

  // Sends a master stamp that leaves the local count d ahead.
  task automatic track(input logic [15:0] d);
    rd16(ADDR_TIME_LO, t0);
    peer_node_model_i.send(5'h09, t0 - AUTO_OFS - d);
    cyc(2);
  endtask

  task automatic speed(input string what, input logic [15:0] ticks);
    rd16(ADDR_TIME_LO, t0);
    cyc(2043);
    rd16(ADDR_TIME_LO, t1);
    chk(what, t1 - t0, ticks);
  endtask

  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end

  initial
  begin
    cyc(6);
    chk("idle pulse pin", digitPulseOut_n, 1'b1);
    reset_n = 1'b1;
    cyc(5);
    chk("slave role", clockMaster, 1'b0);
    rd(ADDR_INT_STATUS, v);
    chk("unlock bit", v, 16'h0001);
    rd(8'h20, v);
    chk("unmapped read", v, 16'h0000);
    wr(ADDR_MODE, 8'h01);
    cyc(1);
    chk("stamp enable", txStampEnable, 1'b1);
    wr(ADDR_MODE, 8'h00);
    cyc(1);
    chk("stamp disable", txStampEnable, 1'b0);
    rd16(ADDR_TIME_LO, t0);
    cyc(3197);
    rd16(ADDR_TIME_LO, t1);
    chk("free run ticks", t1 - t0, 16'h0064);
    wr(ADDR_CARRY_LO, 8'h01);
    rd(ADDR_CARRY_LO, v);
    chk("digit select", v, 16'h0001);
    cyc(70);
    low    = 0;
    run    = 0;
    maxRun = 0;
    repeat (256)
    begin
      @(negedge sys_clk);
      run    = (digitPulseOut_n === 1'b0) ? run + 1 : 0;
      low    = (digitPulseOut_n === 1'b0) ? low + 1 : low;
      maxRun = (run > maxRun) ? run : maxRun;
    end
    chk("pulse low cycles", low[15:0], 16'h0080);
    chk("pulse width", maxRun[15:0], 16'h0020);
    wr(ADDR_MASTER_ID, 8'h09);
    peer_node_model_i.send(5'h07, 16'h5000);
    peer_node_model_i.send(5'h09, 16'h1234);
    rd16(ADDR_TIME_LO, t1);
    near("preset value", t1, 16'h1234 + AUTO_OFS);
    track(16'h0005);
    rd16(ADDR_DIFF_LO, v);
    chk("ahead direction", v[15], 1'b0);
    near("ahead magnitude", v & 16'h7FFF, 16'h0005);
    chk("unlock on big diff", syncUnlockedFlag, 1'b1);
    speed("slowed ticks", 16'h003E);
    track(16'hFFFC);
    rd16(ADDR_DIFF_LO, v);
    chk("behind direction", v[15], 1'b1);
    near("behind magnitude", v & 16'h7FFF, 16'h0003);
    speed("hastened ticks", 16'h0042);
    track(16'h0000);
    track(16'h0000);
    chk("two in window", syncUnlockedFlag, 1'b1);
    track(16'h0000);
    chk("locked", syncUnlockedFlag, 1'b0);
    rd(ADDR_INT_STATUS, v);
    chk("lock bit", v, 16'h0000);
    track(16'h0005);
    chk("unlock again", syncUnlockedFlag, 1'b1);
    wr(ADDR_CARRY_HI, 8'h85);
    rd(ADDR_CARRY_HI, v);
    chk("offset config", v, 16'h0085);
    wr(ADDR_MASTER_ID, 8'h09);
    peer_node_model_i.send(5'h09, 16'h2000);
    rd16(ADDR_TIME_LO, t1);
    near("auto offset kept", t1, 16'h2000 + AUTO_OFS);
    prescaleSelectPin = 3'h4;
    wr(ADDR_MODE, 8'h02);
    rd16(ADDR_TIME_LO, t1);
    chk("stamp value", txStampValue, t1);
    wr(ADDR_MODE, 8'h00);
    cyc(2);
    peer_node_model_i.send(5'h09, 16'h3000);
    rd16(ADDR_TIME_LO, t1);
    near("manual offset", t1, 16'h3005);
    nodeIdPin = 5'h09;
    cyc(5);
    chk("master role", clockMaster, 1'b1);
    chk("master stamps", txStampEnable, 1'b1);
    chk("master locked", syncUnlockedFlag, 1'b0);
    wr(ADDR_MODE, 8'h80);
    cyc(3);
    chk("locked after soft reset", syncUnlockedFlag, 1'b0);
    rd16(ADDR_TIME_LO, t1);
    chk("cleared by soft reset", t1, 16'h0000);
    reset_n = 1'b0;
    cyc(2);
    chk("unlocked in reset", syncUnlockedFlag, 1'b1);
    reset_n = 1'b1;
    wr(ADDR_MASTER_ID, 8'h09);
    cyc(5);
    chk("master relocks", syncUnlockedFlag, 1'b0);
    close_out();
  end
endmodule // network_time_sync_counter_tb
`default_nettype wire
